// [rtl/fcsc_flash_regs.sv]
`timescale 1ns/10ps
`include "fcsc_regs.svh"
module fcsc_flash_regs
   import fcsc_pkg::*;
(
   input  wire logic                     clk,
   input  wire logic                     nrst,
   input  wire logic [`FCSC_ADDR_W-1:0]  addr,
   input  wire logic [7:0]               wdata,
   input  wire logic                     wr,
   input  wire logic                     rd,
   output logic      [7:0]               rdata,
   input  wire logic                     nv_valid,
   input  wire logic [7:0]               nv_security_byte,
   input  wire logic                     backdoor_unlock,
   input  wire logic                     command_buffer_empty_flag,
   input  wire logic                     command_complete_flag,
   output logic                          flash_timing_tick,
   output logic                          backdoor_enabled,
   output logic                          device_unsecured,
   output logic                          array_key_mode,
   output logic                          array_read_invalid,
   output logic                          flash_irq,
   output logic                          event_irq
);
   fcsc_byte_t clkdiv;
   fcsc_byte_t security_options;
   fcsc_byte_t config_r;
   logic [1:0] irq_stat;
   logic [1:0] irq_mask;
   logic [2:0] pre_cnt;
   logic [5:0] div_cnt;
   logic       nv_loaded;
   logic       beif_q;
   logic       command_complete_flag_q;

   wire wr_clkdiv = wr && (addr == `FCSC_OFF_CLKDIV);
   wire wr_config = wr && (addr == `FCSC_OFF_CONFIG);
   wire wr_stat   = wr && (addr == `FCSC_OFF_IRQ_STAT);
   wire wr_mask   = wr && (addr == `FCSC_OFF_IRQ_MASK);
   wire divider_loaded_flag = clkdiv[`FCSC_BIT_LOADED];
   wire prescale_by_eight   = clkdiv[`FCSC_BIT_PRESCALE];
   wire [5:0] divide_value  = clkdiv[5:0];
   wire [1:0] backdoor_enable_code = security_options[7:6];
   wire [1:0] protection_level     = security_options[1:0];
   wire key_on = (backdoor_enable_code == `FCSC_CODE_ON);
   wire buffer_empty_irq_enable = config_r[`FCSC_BIT_BEIE];
   wire command_done_irq_enable = config_r[`FCSC_BIT_COMMAND_DONE_IRQ_ENABLE];
   wire key_write_select        = config_r[`FCSC_BIT_KEYW];
   // prescaler stage: /8 or pass-through, then /(n+1); max 8*64 = 512
   wire pre_tick = !prescale_by_eight || (pre_cnt == `FCSC_PRESCALE_DIV);
   wire div_tick = pre_tick && (div_cnt == divide_value);
   wire [1:0] events = {command_buffer_empty_flag & ~beif_q,
                        command_complete_flag & ~command_complete_flag_q};
   wire [7:0] next_config;
   assign next_config = {wdata[`FCSC_BIT_BEIE], wdata[`FCSC_BIT_COMMAND_DONE_IRQ_ENABLE],
                         key_on ? wdata[`FCSC_BIT_KEYW] : key_write_select,
                         5'h00};
   wire [7:0] rd_mux =
      (addr == `FCSC_OFF_CLKDIV)   ? clkdiv :
      (addr == `FCSC_OFF_SECURITY) ? security_options :
      (addr == `FCSC_OFF_CONFIG)   ? config_r :
      (addr == `FCSC_OFF_IRQ_STAT) ? {6'h00, irq_stat} :
      (addr == `FCSC_OFF_IRQ_MASK) ? {6'h00, irq_mask} :
      8'h00;                                                     // unmapped reads zero

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         clkdiv <= `FCSC_CLKDIV_RST;
      end else if (wr_clkdiv && !divider_loaded_flag) begin
         clkdiv <= {1'b1, wdata[6:0]};
      end
   end

   // security byte has no bus write path; only NV load and backdoor unlock write it
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         security_options <= 8'h00;
         nv_loaded        <= 1'b0;
      end else if (nv_valid && !nv_loaded) begin
         security_options <= nv_security_byte;
         nv_loaded        <= 1'b1;
      end else if (backdoor_unlock && key_on) begin
         security_options[1:0] <= `FCSC_FORCED_LEVEL;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         config_r <= `FCSC_CONFIG_RST;
      end else if (wr_config) begin
         config_r <= next_config;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pre_cnt <= 3'h0;
         div_cnt <= 6'h00;
      end else begin
         pre_cnt <= prescale_by_eight ? pre_cnt + 3'h1 : 3'h0;
         if (pre_tick) begin
            div_cnt <= div_tick ? 6'h00 : div_cnt + 6'h01;
         end
      end
   end

   // set wins over write-one-to-clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_stat <= 2'h0;
         irq_mask <= 2'h0;
         beif_q   <= 1'b0;
         command_complete_flag_q   <= 1'b0;
         rdata    <= 8'h00;
         flash_timing_tick <= 1'b0;
      end else begin
         beif_q   <= command_buffer_empty_flag;
         command_complete_flag_q   <= command_complete_flag;
         irq_stat <= (irq_stat & ~(wr_stat ? wdata[1:0] : 2'h0)) | events;
         if (wr_mask) begin
            irq_mask <= wdata[1:0];
         end
         rdata <= rd ? rd_mux : 8'h00;
         flash_timing_tick <= div_tick && divider_loaded_flag;
      end
   end

   assign backdoor_enabled   = key_on;
   assign device_unsecured   = (protection_level == `FCSC_FORCED_LEVEL);
   assign array_key_mode     = key_write_select;
   assign array_read_invalid = key_write_select;
   // level, follows flags directly until flag or enable drops
   assign flash_irq = (buffer_empty_irq_enable & command_buffer_empty_flag) |
                      (command_done_irq_enable & command_complete_flag);
   assign event_irq = |(irq_stat & irq_mask);
endmodule

// [rtl/fcsc_regs.svh]
`ifndef FCSC_REGS_SVH
`define FCSC_REGS_SVH
`define FCSC_ADDR_W        4
`define FCSC_OFF_CLKDIV    4'h0
`define FCSC_OFF_SECURITY  4'h1
`define FCSC_OFF_TEST      4'h2
`define FCSC_OFF_CONFIG    4'h3
`define FCSC_OFF_IRQ_STAT  4'h4
`define FCSC_OFF_IRQ_MASK  4'h5
`define FCSC_BIT_LOADED    7
`define FCSC_BIT_PRESCALE  6
`define FCSC_BIT_BEIE      7
`define FCSC_BIT_COMMAND_DONE_IRQ_ENABLE      6
`define FCSC_BIT_KEYW      5
`define FCSC_CODE_ON       2'h2
`define FCSC_PRESCALE_DIV  3'h7
`define FCSC_CLKDIV_RST    8'h00
`define FCSC_CONFIG_RST    8'h00
`define FCSC_FORCED_LEVEL  2'h2
`endif

// [rtl/fcsc_pkg.sv]
package fcsc_pkg;
   typedef logic [7:0] fcsc_byte_t;
endpackage

// [verif/fcsc_regs_asserts.sv]
`timescale 1ns/10ps
`include "fcsc_regs.svh"
module fcsc_regs_asserts
   import fcsc_pkg::*;
(
   input wire logic                    clk,
   input wire logic                    nrst,
   input wire logic [`FCSC_ADDR_W-1:0] addr,
   input wire logic                    rd,
   input wire logic [7:0]              rdata,
   input wire logic                    backdoor_unlock,
   input wire logic                    command_buffer_empty_flag,
   input wire logic                    command_complete_flag,
   input wire logic                    backdoor_enabled,
   input wire logic                    device_unsecured,
   input wire logic                    array_key_mode,
   input wire logic                    array_read_invalid,
   input wire logic                    flash_irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   a_key_code: assert property (rd && addr == 4'h1 |=> backdoor_enabled == (rdata[7:6] == 2'h2))
      else $error("backdoor enable disagrees with code");
   a_sec_level: assert property (rd && addr == 4'h1 |=> device_unsecured == (rdata[1:0] == 2'h2))
      else $error("unsecured flag disagrees with level");
   a_unsec_force: assert property (backdoor_unlock && backdoor_enabled |=> device_unsecured)
      else $error("unlock did not unsecure");
   a_test_zero: assert property (rd && addr == 4'h2 |=> rdata == 8'h00)
      else $error("test register not zero");
   a_cfg_zero: assert property (rd && addr == 4'h3 |=> rdata[4:0] == 5'h00)
      else $error("config low bits not zero");
   a_key_gate: assert property ($rose(array_key_mode) |-> $past(backdoor_enabled))
      else $error("key write taken while disabled");
   a_irq_cause: assert property (flash_irq |-> command_buffer_empty_flag || command_complete_flag)
      else $error("irq without flag");
   a_key_mirror: assert property (array_key_mode == array_read_invalid)
      else $error("key mode and read invalid differ");
   c_unlock: cover property (backdoor_unlock && backdoor_enabled);
   c_irq: cover property (flash_irq);
   c_key: cover property (array_key_mode);
endmodule
bind fcsc_flash_regs fcsc_regs_asserts fcsc_regs_asserts_i (.*);

// [verif/tb_top.sv]
`timescale 1ns/10ps
`include "fcsc_regs.svh"
module tb_top;
   import fcsc_pkg::*;
   logic clk = 0, nrst = 0, wr = 0, rd = 0, nv_valid = 0, backdoor_unlock = 0;
   logic command_buffer_empty_flag = 0, command_complete_flag = 0;
   logic [`FCSC_ADDR_W-1:0] addr = 0;
   fcsc_byte_t wdata = 0, nv_security_byte = 0, rdata, sec, dv;
   logic flash_timing_tick, backdoor_enabled, device_unsecured, array_key_mode;
   logic array_read_invalid, flash_irq, event_irq;
   int mismatches = 0, cmp_count = 0, n;
   logic [31:0] r = 32'h9cb17a0b;
   fcsc_flash_regs fcsc_flash_regs_i (.*);
   initial forever #5 clk = ~clk;
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task wrap_up;
      if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(string nm, logic [7:0] e, logic [7:0] s);
      cmp_count++;
      if (s !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task wreg(logic [3:0] a, fcsc_byte_t d);
      addr <= a; wdata <= d; wr <= 1;
      @(posedge clk); wr <= 0;
      @(posedge clk);
   endtask
   task rreg(logic [3:0] a, fcsc_byte_t e, string nm);
      addr <= a; rd <= 1;
      @(posedge clk); rd <= 0;
      #1 chk(nm, e, rdata);
      @(posedge clk);
   endtask
   // bounded wait for the next timing tick, n counts cycles
   task wt;
      n = 0;
      do begin @(negedge clk); n++; end while (flash_timing_tick !== 1 && n < 600);
      if (n >= 600) begin mismatches++; wrap_up; end
   endtask
   initial begin
      for (int k = 0; k < 4; k++) begin
         nrst <= 0; repeat (2) @(posedge clk); nrst <= 1; @(posedge clk);
         r = lfsr(r);
         sec = {k[1:0], r[5:2], k[0], k[1]};
         rreg(1, 8'h00, "sec_pre");
         nv_security_byte <= sec; nv_valid <= 1; @(posedge clk); nv_valid <= 0; @(posedge clk);
         wreg(1, ~sec); wreg(2, 8'hff);
         rreg(1, sec, "sec");
         rreg(2, 8'h00, "test");
         chk("en", k == 2, backdoor_enabled);
         chk("unsec", k == 1, device_unsecured);
         wreg(3, 8'hff);
         rreg(3, {2'b11, k == 2, 5'h00}, "cfg");
         chk("key", k == 2, array_read_invalid);
         backdoor_unlock <= 1; @(posedge clk); backdoor_unlock <= 0; @(posedge clk);
         rreg(1, (k == 2) ? {sec[7:2], 2'h2} : sec, "force");
         command_buffer_empty_flag <= 1; @(negedge clk);
         chk("irq_be", 1, flash_irq);
         @(posedge clk); wreg(3, 8'h40);
         chk("irq_off", 0, flash_irq);
         command_complete_flag <= 1; @(negedge clk);
         chk("irq_cc", 1, flash_irq);
         @(posedge clk); command_buffer_empty_flag <= 0; command_complete_flag <= 0;
         @(posedge clk); rreg(4, 8'h03, "stat");
         wreg(5, 8'h01); chk("evt", 1, event_irq);
         wreg(4, 8'h01); chk("evt_clr", 0, event_irq);
         r = lfsr(r);
         dv = (k == 3) ? 8'h7f : {1'b0, k[0], r[5:0]}; // only k==3 lands in band
         wreg(0, dv); wreg(0, ~dv);
         rreg(0, {1'b1, dv[6:0]}, "div");
         wt; wt;
         chk("period", 1, n == (dv[6] ? 8 : 1) * (dv[5:0] + 1));
      end
      wrap_up;
   end
endmodule
